/* design/clock_sync_map.svh */
/*
  Register offsets, field positions, reset values and timing figures of
  the sample clock divider and sync block.
  Assumes it is included by bare name after the package is compiled.
*/
`ifndef CLOCK_SYNC_MAP_SVH
`define CLOCK_SYNC_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLOCK_SYNC_CONTROL 8'h3A
`define OFS_CLOCK_DIVIDE 8'h3B
`define OFS_CLOCK_STATUS 8'h3C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define BIT_RESYNC_EN 1
`define DIV_FIELD_MSB 2
`define RST_CLOCK_SYNC_CONTROL 8'h00
`define RST_CLOCK_DIVIDE 8'h00

// ----------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 5.0
`define RELOCK_MIN_US 1.5
`define RELOCK_MAX_US 5.0
`define STAB_MIN_RATE_MHZ 40.0

`endif

/* design/clock_sync_pkg.sv */
/*
  Types shared by the sample clock divider and sync block.
  Assumes nothing of its surroundings.
*/
package clock_sync_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } reg_rsp_t;

  typedef enum logic [1:0] {
    STAB_BYPASS,
    STAB_SETTLE,
    STAB_LOCKED
  } stab_state_t;

endpackage

/* design/sync_edge_detect.sv */
/*
  Brings a level into the clock domain through a flip-flop chain and
  flags each rising edge with a one-cycle pulse.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/100ps
module sync_edge_detect #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic levelIn,
  output logic risePulse
);

  logic [STAGES-1:0] chain;
  logic prevLevel;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], levelIn};
    end
  end

  // ----------------------------------------------------------------
  // Edge flag, last stage only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      prevLevel <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      prevLevel <= chain[STAGES-1];
      risePulse <= chain[STAGES-1] & ~prevLevel;
    end
  end

endmodule

/* design/sample_clock_divider_sync.sv */
/*
  Sample clock conditioning: integer divider with sync realignment and
  a duty cycle stabilizer with lock tracking and bypass.
  Assumes the sample clock and sync pins are sampled by clk, and that
  register requests arrive as one-cycle strobes on clk.
*/
`timescale 1ns/100ps
`include "clock_sync_map.svh"

// Contract
// R1: The incoming sample clock is divided by any whole ratio 1 to 8.
// R2: With resync enable set, every sync pulse realigns the divider.
// R3: A valid sync pulse returns the divider counter to its start state.
// R4: The stabilizer keeps the rising edge and makes a 50% high time.
// R5: Below about 40 MHz the stabilizer stands aside, raw duty is used.
// R6: The system waits 1.5 to 5 us after a rate change for relock.
// R7: While unlocked the stabilizer is bypassed, raw duty passes.
// R8: Each sample is taken on the conversion clock's rising edge.
// R9: Sync is resynchronised inside; the driver keeps it clock-aligned.
// R10: With resync disabled, sync pulses are ignored, divider runs free.
module sample_clock_divider_sync #(
  parameter int DIV_BITS = 3,
  parameter int PERIOD_BITS = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sampleClkIn,
  input wire logic syncIn,
  input wire clock_sync_pkg::reg_req_t regReq,
  output clock_sync_pkg::reg_rsp_t regRsp,
  output logic convClk,
  output logic sampleStrobe,
  output logic stabLocked
);
  import clock_sync_pkg::*;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  // Least relock wait rounds up; the device locks at the earliest point
  localparam int RELOCK_CYC =
    int'($ceil(`RELOCK_MIN_US * 1000.0 / `CLK_PERIOD_NS));
  // Longest period still counted as fast enough, rounds down
  localparam int MAX_PERIOD_CYC =
    int'($floor(1000.0 / (`STAB_MIN_RATE_MHZ * `CLK_PERIOD_NS)));
  localparam logic [PERIOD_BITS-1:0] MAX_PERIOD =
    PERIOD_BITS'(MAX_PERIOD_CYC);
  localparam logic [10:0] RELOCK_LAST = 11'(RELOCK_CYC - 1);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] clockSyncControl;
  logic [DIV_BITS-1:0] ratioM1;
  logic resyncEn;

  assign resyncEn = clockSyncControl[`BIT_RESYNC_EN];

  always_ff @(posedge clk) begin
    if (srst) begin
      clockSyncControl <= `RST_CLOCK_SYNC_CONTROL;
      ratioM1 <= DIV_BITS'(`RST_CLOCK_DIVIDE);
    end else if (regReq.wr) begin
      if (regReq.addr == `OFS_CLOCK_SYNC_CONTROL) begin
        clockSyncControl <= regReq.data;
      end
      if (regReq.addr == `OFS_CLOCK_DIVIDE) begin
        ratioM1 <= regReq.data[`DIV_FIELD_MSB:0]; // [R1]
      end
    end
  end

  stab_state_t stabState;

  // Unmapped reads answer zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regRsp <= '0;
    end else begin
      regRsp.valid <= regReq.rd;
      regRsp.data <= 8'h00;
      if (regReq.rd) begin
        unique case (regReq.addr)
          `OFS_CLOCK_SYNC_CONTROL: begin
            regRsp.data <= clockSyncControl;
          end
          `OFS_CLOCK_DIVIDE: begin
            regRsp.data <= {5'h00, ratioM1};
          end
          `OFS_CLOCK_STATUS: begin
            regRsp.data <= {5'h00, stabState == STAB_SETTLE,
                            stabState == STAB_BYPASS,
                            stabState == STAB_LOCKED};
          end
          default: begin
            regRsp.data <= 8'h00;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync input
  // ----------------------------------------------------------------
  logic syncPulse;
  logic realign;

  // Internal resync; external alignment still needed across parts
  sync_edge_detect #(
    .STAGES(2)
  ) u_sync ( // [R9]
    .clk(clk),
    .srst(srst),
    .levelIn(syncIn),
    .risePulse(syncPulse)
  );

  assign realign = syncPulse & resyncEn; // [R2] [R10]

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic inPrev;
  logic inRise;
  logic [DIV_BITS-1:0] divCount;
  logic [DIV_BITS-1:0] next_divCount;
  logic [DIV_BITS:0] halfCount;
  logic rawDiv;
  logic rawPrev;
  logic divRise;

  assign inRise = sampleClkIn & ~inPrev;
  assign divRise = rawDiv & ~rawPrev;
  assign halfCount = {1'b0, ratioM1 >> 1} + {{DIV_BITS{1'b0}}, 1'b1};
  assign next_divCount = (divCount >= ratioM1) ? '0 :
                         divCount + DIV_BITS'(1);

  always_ff @(posedge clk) begin
    if (srst) begin
      inPrev <= 1'b0;
      rawPrev <= 1'b0;
    end else begin
      inPrev <= sampleClkIn;
      rawPrev <= rawDiv;
    end
  end

  // Start state: terminal count, so the next input edge opens a period
  always_ff @(posedge clk) begin
    if (srst) begin
      divCount <= '0;
      rawDiv <= 1'b0;
    end else if (realign) begin
      divCount <= ratioM1; // [R3]
      rawDiv <= 1'b0;
    end else if (ratioM1 == '0) begin
      divCount <= '0;
      rawDiv <= sampleClkIn; // [R1]
    end else if (inRise) begin
      divCount <= next_divCount; // [R1]
      rawDiv <= {1'b0, next_divCount} < halfCount;
    end
  end

  // ----------------------------------------------------------------
  // Period measurement
  // ----------------------------------------------------------------
  logic [PERIOD_BITS-1:0] periodCnt;
  logic [PERIOD_BITS-1:0] lastPeriod;
  logic periodMatch;
  logic tooSlow;

  // One cycle of slack absorbs pin sampling jitter
  assign periodMatch = (periodCnt + PERIOD_BITS'(1) >= lastPeriod) &&
                       (periodCnt <= lastPeriod + PERIOD_BITS'(1));
  assign tooSlow = periodCnt > MAX_PERIOD;

  always_ff @(posedge clk) begin
    if (srst) begin
      periodCnt <= '0;
      lastPeriod <= '0;
    end else if (divRise) begin
      periodCnt <= PERIOD_BITS'(1);
      lastPeriod <= periodCnt;
    end else if (periodCnt != '1) begin
      periodCnt <= periodCnt + PERIOD_BITS'(1);
    end
  end

  // ----------------------------------------------------------------
  // Stabilizer lock tracking
  // ----------------------------------------------------------------
  logic [10:0] settleCnt;

  always_ff @(posedge clk) begin
    if (srst) begin
      stabState <= STAB_BYPASS;
      settleCnt <= '0;
    end else begin
      unique case (stabState)
        STAB_BYPASS: begin
          settleCnt <= '0;
          if (divRise && !tooSlow && periodCnt > PERIOD_BITS'(1)) begin
            stabState <= STAB_SETTLE;
          end
        end
        STAB_SETTLE: begin
          settleCnt <= settleCnt + 11'h001;
          if (tooSlow || (divRise && !periodMatch)) begin
            stabState <= STAB_BYPASS; // [R5] [R7]
          end else if (settleCnt == RELOCK_LAST) begin
            stabState <= STAB_LOCKED; // [R6]
          end
        end
        STAB_LOCKED: begin
          settleCnt <= '0;
          if (tooSlow || (divRise && !periodMatch)) begin
            stabState <= STAB_BYPASS; // [R7]
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Regenerated falling edge
  // ----------------------------------------------------------------
  logic stabHigh;
  logic [PERIOD_BITS-1:0] phase;

  // Rise follows the input edge; only the fall is retimed
  always_ff @(posedge clk) begin
    if (srst) begin
      stabHigh <= 1'b0;
      phase <= '0;
    end else if (divRise) begin
      stabHigh <= 1'b1; // [R4]
      phase <= PERIOD_BITS'(1);
    end else begin
      phase <= phase + PERIOD_BITS'(1);
      if (phase >= (lastPeriod >> 1)) begin
        stabHigh <= 1'b0; // [R4]
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic next_convClk;

  // Bypass hands through the divided clock with its own duty
  assign next_convClk =
    (stabState == STAB_LOCKED) ? stabHigh : rawPrev; // [R7]

  always_ff @(posedge clk) begin
    if (srst) begin
      convClk <= 1'b0;
      sampleStrobe <= 1'b0;
      stabLocked <= 1'b0;
    end else begin
      convClk <= next_convClk;
      sampleStrobe <= next_convClk & ~convClk; // [R8]
      stabLocked <= stabState == STAB_LOCKED;
    end
  end

endmodule

/* verif/sample_clock_divider_sync_checker.sv */
/* Port checker for the sample clock divider.
   Assumes it is bound to the design top; one clock domain. */
`timescale 1ns/100ps
module sample_clock_divider_sync_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic sampleClkIn,
  input wire logic syncIn,
  input wire clock_sync_pkg::reg_req_t regReq,
  input wire clock_sync_pkg::reg_rsp_t regRsp,
  input wire logic convClk,
  input wire logic sampleStrobe,
  input wire logic stabLocked
);
  import clock_sync_pkg::*;
  logic [7:0] inAge;
  logic [7:0] convAge;
  // Saturating ages, so long idles never wrap
  always_ff @(posedge clk) begin
    if (srst) inAge <= 8'hFF;
    else if ($rose(sampleClkIn)) inAge <= 8'h00;
    else if (inAge != 8'hFF) inAge <= inAge + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (srst) convAge <= 8'hFF;
    else if ($rose(convClk)) convAge <= 8'h00;
    else if (convAge != 8'hFF) convAge <= convAge + 8'h01;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_strobe_rise: assert property (sampleStrobe |-> $rose(convClk))
    else $error("strobe off a rise");
  chk_rise_strobe: assert property ($rose(convClk) |-> sampleStrobe)
    else $error("rise without strobe");
  chk_rise_input: assert property ($rose(convClk) |-> inAge <= 8'h04)
    else $error("rise not after input rise");
  chk_locked_fast: assert property
    (stabLocked && $rose(convClk) |-> convAge <= 8'h04)
    else $error("locked on slow clock");
  chk_locked_duty: assert property
    (stabLocked && $fell(convClk) |-> convAge <= 8'h02)
    else $error("locked high time long");
  chk_read_answer: assert property (regReq.rd |=> regRsp.valid)
    else $error("read not answered");
  chk_valid_cause: assert property (regRsp.valid |-> $past(regReq.rd))
    else $error("valid without read");
  chk_reset_quiet: assert property
    ($fell(srst) |-> !convClk && !stabLocked && !regRsp.valid)
    else $error("outputs busy after reset");
  cover property ($rose(stabLocked));
  cover property ($rose(syncIn) ##[1:20] sampleStrobe);
  cover property (regRsp.valid);
endmodule
bind sample_clock_divider_sync sample_clock_divider_sync_checker chk (
  .clk(clk), .srst(srst), .sampleClkIn(sampleClkIn), .syncIn(syncIn),
  .regReq(regReq), .regRsp(regRsp), .convClk(convClk),
  .sampleStrobe(sampleStrobe), .stabLocked(stabLocked));

/* verif/clock_source_model.sv */
/* Sample clock source and sync driver.
   Assumes the bench sets phase lengths in clk cycles. */
`timescale 1ns/100ps
module clock_source_model (
  input wire logic clk,
  input wire logic [31:0] hiCyc,
  input wire logic [31:0] loCyc,
  input wire logic syncReq,
  output logic sampleClkIn,
  output logic syncIn
);
  int ph = 0;
  initial begin
    sampleClkIn = 1'b0;
    syncIn = 1'b0;
  end
  // Moves on the falling edge, clear of the sampling edge
  always @(negedge clk) begin
    ph = (ph + 1) % (hiCyc + loCyc);
    sampleClkIn <= (ph < hiCyc);
    // Sync launched with an input rise, held a whole period
    if (ph == 0) syncIn <= syncReq;
  end
endmodule

/* verif/test_sample_clock_divider_sync.sv */
/* Bench: registers, ratios, duty, lock and sync realignment.
   Assumes the checker binds itself; clock 200 MHz. */
`timescale 1ns/100ps
module test_sample_clock_divider_sync;
  import clock_sync_pkg::*;
  logic clk;
  logic srst = 1'b1;
  logic syncReq = 1'b0;
  logic sampleClkIn;
  logic syncIn;
  reg_req_t regReq = '0;
  reg_rsp_t regRsp;
  logic convClk;
  logic sampleStrobe;
  logic stabLocked;
  int hiCyc = 2;
  int loCyc = 2;
  int num_errors = 0;
  int n_compared = 0;
  int t1;
  int t2;
  sample_clock_divider_sync uut (.clk(clk), .srst(srst),
    .sampleClkIn(sampleClkIn), .syncIn(syncIn), .regReq(regReq),
    .regRsp(regRsp), .convClk(convClk), .sampleStrobe(sampleStrobe),
    .stabLocked(stabLocked));
  clock_source_model src (.clk(clk), .hiCyc(hiCyc), .loCyc(loCyc),
    .syncReq(syncReq), .sampleClkIn(sampleClkIn), .syncIn(syncIn));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wrReg(input logic [7:0] a, v);
    @(negedge clk);
    regReq = {1'b1, 1'b0, a, v};
    @(negedge clk);
    regReq = '0;
  endtask
  // Answer stands only in the cycle after the read edge
  task automatic rdReg(input logic [7:0] a, e);
    @(negedge clk);
    regReq = {1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    cmp("valid", regRsp.valid, 1'b1);
    cmp("rdata", regRsp.data, e);
    regReq = '0;
  endtask
  task automatic waitStrobe(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sampleStrobe !== 1'b1 && n < 400);
  endtask
  task automatic hiTime(output int n);
    waitStrobe(n);
    n = 0;
    while (convClk === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  // Cycles from a strobe to the first strobe well after a sync
  task automatic syncGap(input int k, output int n);
    int s;
    waitStrobe(n);
    n = k * 4;
    repeat (n) @(posedge clk);
    @(negedge clk);
    syncReq = 1'b1;
    s = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      s++;
    end while (!(sampleStrobe === 1'b1 && s > 6) && s < 200);
    @(negedge clk);
    syncReq = 1'b0;
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results;
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    rdReg(8'h3A, 8'h00);
    rdReg(8'h3B, 8'h00);
    rdReg(8'h50, 8'h00);
    wrReg(8'h3B, 8'hFF);
    rdReg(8'h3B, 8'h07);
    wrReg(8'h3A, 8'h02);
    rdReg(8'h3A, 8'h02);
    $display("test registers done");
    for (int r = 1; r <= 8; r++) begin
      wrReg(8'h3B, 8'(r - 1));
      waitStrobe(t1);
      waitStrobe(t1);
      waitStrobe(t1);
      cmp("ratio gap", t1, r * 4);
    end
    $display("test ratios done");
    wrReg(8'h3B, 8'h00);
    hiCyc = 1;
    loCyc = 3;
    // Let the old wave drain before timing a high phase
    repeat (8) @(posedge clk);
    hiTime(t1);
    cmp("bypass high", t1, 1);
    repeat (400) @(posedge clk);
    #1;
    cmp("locked", stabLocked, 1'b1);
    hiTime(t1);
    cmp("locked high", t1, 2);
    rdReg(8'h3C, 8'h01);
    @(negedge clk);
    loCyc = 7;
    repeat (40) @(posedge clk);
    hiTime(t1);
    cmp("slow high", t1, 1);
    cmp("slow lock", stabLocked, 1'b0);
    rdReg(8'h3C, 8'h02);
    $display("test duty done");
    @(negedge clk);
    hiCyc = 2;
    loCyc = 2;
    wrReg(8'h3B, 8'h03);
    syncGap(1, t1);
    syncGap(2, t2);
    cmp("sync shift", t2 - t1, 4);
    cmp("sync realign", t1 < 16, 1);
    wrReg(8'h3A, 8'h00);
    syncGap(1, t1);
    cmp("free run", t1, 16);
    $display("test sync done");
    results;
  end
endmodule
